// >>> design/srvd_cfg.svh
`ifndef SRVD_CFG_SVH
`define SRVD_CFG_SVH
// register offsets inside the expanded register banks
`define SRVD_OFS_STOP_RECOVERY 8'h0b
`define SRVD_OFS_VOLTAGE_DETECT 8'h0c
// stop recovery config field positions
`define SRVD_SRC_FLAG_BIT 7
`define SRVD_SRC_POL_BIT 6
`define SRVD_SRC_DELAY_BIT 5
`define SRVD_SRC_SEL_HI 4
`define SRVD_SRC_SEL_LO 2
`define SRVD_SRC_DIV_BIT 0
// voltage detect field positions
`define SRVD_VD_HIGH_BIT 2
`define SRVD_VD_LOW_BIT 1
`define SRVD_VD_EN_BIT 0
// reset values
`define SRVD_CFG_RESET 8'h00
// divide ratio of core and timer clocks
`define SRVD_DIV_RATIO 5'd16
`define SRVD_DIV_LAST 4'hf
// settling time after enable
`define SRVD_SETTLE_NS 20000
`define SRVD_CLK_PERIOD_NS 4
`define SRVD_SETTLE_CYCLES ((`SRVD_SETTLE_NS + `SRVD_CLK_PERIOD_NS - 1) / `SRVD_CLK_PERIOD_NS)
`define SRVD_SETTLE_W 13
`endif

// >>> design/srvd_pkg.sv
`default_nettype none
package srvd_pkg;
    typedef enum logic [1:0] {
        SRVD_MON_OFF,
        SRVD_MON_SETTLE,
        SRVD_MON_VALID
    } srvd_mon_state_t;
endpackage : srvd_pkg
`default_nettype wire

// >>> design/srvd_stop_recovery_voltage.sv
`include "srvd_cfg.svh"
`default_nettype none
// Overview of operation
// - recovery config write-only except read-only top
// - top bit set on recovery, cleared by reset
// - bit 6 picks recovery source level polarity
// - bit 5 picks post-recovery reset delay length
// - bits 4..2 select the recovery source
// - bit 0 divides core and timer clocks by 16
// - monitoring runs only while enable bit set
// - flags invalid for 20us after enable
// - bit 2 reads high supply flag
// - bit 1 reads low supply flag
// - low flag while enabled sets request 5
// - request 5 latched until software clear
// - mask decides interrupt versus pollable flag
module srvd_stop_recovery_voltage
    import srvd_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic stop_recovered,
    input wire logic [7:0] recovery_sources,
    input wire logic supply_above_high,
    input wire logic supply_below_low,
    input wire logic low_supply_request_clear,
    input wire logic interrupt_mask_bit5,
    output logic recovery_trigger,
    output logic recovery_polarity_high,
    output logic recovery_long_delay,
    output logic [2:0] recovery_source_sel,
    output logic clock_div16,
    output logic div_clock_tick,
    output logic supply_monitor_on,
    output logic low_supply_request,
    output logic low_supply_irq
);
    logic [7:0] stop_recovery_config_reg;
    logic [7:0] voltage_detect_ctrl_reg;
    logic [3:0] div_count_reg;
    logic [`SRVD_SETTLE_W-1:0] settle_count_reg;
    srvd_mon_state_t mon_state_reg;
    logic high_supply_flag;
    logic low_supply_flag;
    logic flags_valid;
    logic wr_stop;
    logic wr_vd;
    logic [3:0] div_count_next;
    logic [`SRVD_SETTLE_W-1:0] settle_count_next;
    srvd_mon_state_t mon_state_next;
    logic low_supply_request_next;
    logic [7:0] rdata_next;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        addr_hit = (a == ofs);
    endfunction : addr_hit

    assign wr_stop = reg_wr && addr_hit(reg_addr, `SRVD_OFS_STOP_RECOVERY);
    assign wr_vd = reg_wr && addr_hit(reg_addr, `SRVD_OFS_VOLTAGE_DETECT);

    // ****************************************
    // stop recovery configuration
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stop_recovery_config_reg <= `SRVD_CFG_RESET;
        end else begin
            if (wr_stop) begin
                // top bit is not software writable
                stop_recovery_config_reg[6:0] <= reg_wdata[6:0];
            end
            // set only by hardware; only reset clears it
            if (stop_recovered) begin
                stop_recovery_config_reg[`SRVD_SRC_FLAG_BIT] <= 1'b1;
            end
        end
    end

    assign recovery_polarity_high = stop_recovery_config_reg[`SRVD_SRC_POL_BIT];
    assign recovery_long_delay = stop_recovery_config_reg[`SRVD_SRC_DELAY_BIT];
    assign recovery_source_sel = stop_recovery_config_reg[`SRVD_SRC_SEL_HI:`SRVD_SRC_SEL_LO];
    assign clock_div16 = stop_recovery_config_reg[`SRVD_SRC_DIV_BIT];

    // level at the selected source, xnor-ed so the polarity bit picks the level that triggers
    assign recovery_trigger = ~(recovery_sources[recovery_source_sel] ^ recovery_polarity_high);

    // ****************************************
    // clock divider
    // ****************************************
    // a tick enable rather than a derived clock keeps one clock domain
    // counter parks at zero while undivided, so the first divided tick is a full period away
    always_comb begin
        div_count_next = 4'h0;
        if (clock_div16) begin
            div_count_next = div_count_reg + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_count_reg <= 4'h0;
        end else begin
            div_count_reg <= div_count_next;
        end
    end

    assign div_clock_tick = clock_div16 ? (div_count_reg == `SRVD_DIV_LAST) : 1'b1;

    // ****************************************
    // voltage detect control
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            voltage_detect_ctrl_reg <= `SRVD_CFG_RESET;
        end else if (wr_vd) begin
            voltage_detect_ctrl_reg <= {7'h00, reg_wdata[`SRVD_VD_EN_BIT]};
        end
    end

    assign supply_monitor_on = voltage_detect_ctrl_reg[`SRVD_VD_EN_BIT];

    // ****************************************
    // settling window
    // ****************************************
    // disabling restarts the window, so a quick off/on never shows unsettled flags
    always_comb begin
        mon_state_next = mon_state_reg;
        settle_count_next = settle_count_reg;
        if (!supply_monitor_on) begin
            mon_state_next = SRVD_MON_OFF;
            settle_count_next = '0;
        end else begin
            unique case (mon_state_reg)
                SRVD_MON_OFF: begin
                    mon_state_next = SRVD_MON_SETTLE;
                    settle_count_next = '0;
                end
                SRVD_MON_SETTLE: begin
                    settle_count_next = settle_count_reg + `SRVD_SETTLE_W'(1);
                    if (settle_count_reg == `SRVD_SETTLE_W'(`SRVD_SETTLE_CYCLES - 2)) begin
                        mon_state_next = SRVD_MON_VALID;
                    end
                end
                SRVD_MON_VALID: begin
                    mon_state_next = SRVD_MON_VALID;
                end
                default: begin
                    mon_state_next = SRVD_MON_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mon_state_reg <= SRVD_MON_OFF;
            settle_count_reg <= '0;
        end else begin
            mon_state_reg <= mon_state_next;
            settle_count_reg <= settle_count_next;
        end
    end

    // flags are masked until the comparators have settled
    assign flags_valid = supply_monitor_on && (mon_state_reg == SRVD_MON_VALID);
    assign high_supply_flag = flags_valid && supply_above_high;
    assign low_supply_flag = flags_valid && supply_below_low;

    // ****************************************
    // low supply request
    // ****************************************
    always_comb begin
        low_supply_request_next = low_supply_request;
        if (low_supply_flag) begin
            // a set in the clear cycle wins, so no low event is lost
            low_supply_request_next = 1'b1;
        end else if (low_supply_request_clear) begin
            low_supply_request_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            low_supply_request <= 1'b0;
        end else begin
            low_supply_request <= low_supply_request_next;
        end
    end

    assign low_supply_irq = low_supply_request && interrupt_mask_bit5;

    // ****************************************
    // read back
    // ****************************************
    // unmapped or idle cycles return zero
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd && addr_hit(reg_addr, `SRVD_OFS_STOP_RECOVERY)) begin
            // write-only bits read as zero
            rdata_next = {stop_recovery_config_reg[`SRVD_SRC_FLAG_BIT], 7'h00};
        end else if (reg_rd && addr_hit(reg_addr, `SRVD_OFS_VOLTAGE_DETECT)) begin
            rdata_next = {5'h00, high_supply_flag, low_supply_flag, supply_monitor_on};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_next;
        end
    end
endmodule : srvd_stop_recovery_voltage
`default_nettype wire

// >>> dv/srvd_checker.sv
`default_nettype none
// ***
// port checks
// ***
module srvd_checker (
    input wire logic core_clk, rst, reg_wr, clock_div16, div_clock_tick,
    input wire logic recovery_trigger, recovery_polarity_high, recovery_long_delay,
    input wire logic supply_monitor_on, supply_below_low, interrupt_mask_bit5,
    input wire logic low_supply_request, low_supply_request_clear, low_supply_irq,
    input wire logic [7:0] reg_addr, reg_wdata, recovery_sources,
    input wire logic [2:0] recovery_source_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_tr; recovery_trigger == (recovery_sources[recovery_source_sel] == recovery_polarity_high); endproperty
    a_tr: assert property (p_tr) else $error("bad trigger");
    property p_cf; reg_wr && reg_addr == 8'h0b |=> (({recovery_polarity_high, recovery_long_delay,
        recovery_source_sel, 1'b0, clock_div16} ^ $past(reg_wdata)) & 8'h7d) == 8'h00; endproperty
    a_cf: assert property (p_cf) else $error("bad config");
    property p_en; reg_wr && reg_addr == 8'h0c |=> supply_monitor_on == $past(reg_wdata[0]); endproperty
    a_en: assert property (p_en) else $error("bad enable");
    // divided tick may come back at once when the divider is switched off
    property p_dv; clock_div16 && div_clock_tick |=> (!div_clock_tick || !clock_div16)[*8]; endproperty
    a_dv: assert property (p_dv) else $error("tick too soon");
    property p_rq; $rose(low_supply_request) |-> $past(supply_monitor_on) && $past(supply_below_low); endproperty
    a_rq: assert property (p_rq) else $error("bad request");
    property p_st; $rose(supply_monitor_on) |=> (!$rose(low_supply_request))[*8]; endproperty
    a_st: assert property (p_st) else $error("request in settle");
    property p_hd; low_supply_request && !low_supply_request_clear |=> low_supply_request; endproperty
    a_hd: assert property (p_hd) else $error("request lost");
    property p_iq; low_supply_irq == (low_supply_request && interrupt_mask_bit5); endproperty
    a_iq: assert property (p_iq) else $error("bad irq");
endmodule : srvd_checker
bind srvd_stop_recovery_voltage srvd_checker u_chk (.*);
`default_nettype wire

// >>> dv/srvd_stop_recovery_voltage_bench.sv
`default_nettype none
module srvd_stop_recovery_voltage_bench import srvd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, stop_recovered = 0, supply_above_high = 0;
    logic supply_below_low = 0, low_supply_request_clear = 0, interrupt_mask_bit5 = 0, rd_d = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, recovery_sources = 0, reg_rdata;
    logic [2:0] recovery_source_sel;
    logic recovery_trigger, recovery_polarity_high, recovery_long_delay, clock_div16, div_clock_tick;
    logic supply_monitor_on, low_supply_request, low_supply_irq;
    logic [7:0] q[$];
    int err_total = 0, samples_checked = 0, i;
    int unsigned s = 28;
    srvd_stop_recovery_voltage dut (.*);
    function automatic logic [7:0] rnd();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s[7:0];
    endfunction : rnd
    task chk(logic [7:0] g, logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task test_done;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    // w=1 writes d, w=0 reads and notes d as the expected answer
    task acc(logic w, logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        if (w) reg_wr <= 1;
        else begin
            reg_rd <= 1;
            q.push_back(d);
        end
        @(posedge core_clk);
        reg_wr <= 0;
        reg_rd <= 0;
    endtask : acc
    // ***
    // read data monitor
    // ***
    always @(posedge core_clk) begin
        if (rd_d) chk(reg_rdata, q.pop_front());
        rd_d <= reg_rd;
    end
    initial forever #2 core_clk = ~core_clk;
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        test_done;
    end
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 0;
        acc(0, 8'h0b, 8'h00);
        acc(0, 8'h0c, 8'h00);
        acc(0, 8'h55, 8'h00);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            recovery_sources <= rnd();
            acc(1, 8'h0b, (rnd() | 8'h80) & 8'he3 | 8'(i << 2));
            acc(0, 8'h0b, 8'h00);
        end
        $display("config test done");
        stop_recovered <= 1;
        @(posedge core_clk);
        stop_recovered <= 0;
        acc(0, 8'h0b, 8'h80);
        acc(1, 8'h0b, 8'h01);
        acc(0, 8'h0b, 8'h80);
        $display("recovery test done");
        supply_below_low <= 1;
        acc(1, 8'h0c, 8'hff);
        acc(0, 8'h0c, 8'h01);
        repeat (5005) @(posedge core_clk);
        acc(0, 8'h0c, 8'h03);
        @(negedge core_clk);
        chk(low_supply_request, 1);
        chk(low_supply_irq, 0);
        @(posedge core_clk);
        supply_below_low <= 0;
        supply_above_high <= 1;
        interrupt_mask_bit5 <= 1;
        acc(0, 8'h0c, 8'h05);
        @(negedge core_clk);
        chk(low_supply_request, 1);
        chk(low_supply_irq, 1);
        @(posedge core_clk);
        low_supply_request_clear <= 1;
        @(posedge core_clk);
        low_supply_request_clear <= 0;
        acc(1, 8'h0c, 8'h00);
        supply_below_low <= 1;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        chk(low_supply_request, 0);
        acc(0, 8'h0c, 8'h00);
        $display("supply test done");
        test_done;
    end
endmodule : srvd_stop_recovery_voltage_bench
`default_nettype wire
